// >>> design/wdcc_regs.vh
// Register map, field positions and reset values of the watchdog control block.
// Included by every design file of the block; definitions only.
`ifndef WDCC_REGS_VH
`define WDCC_REGS_VH
`define WDCC_ADDR_W 12
`define WDCC_OFF_CONTROL 12'h008
`define WDCC_OFF_INT_CLEAR 12'h00C
`define WDCC_OFF_RAW_STATUS 12'h010
`define WDCC_OFF_MASKED_STATUS 12'h014
`define WDCC_OFF_IRQ_STATUS 12'h020
`define WDCC_OFF_IRQ_MASK 12'h024
`define WDCC_BIT_INT_ENABLE 0
`define WDCC_BIT_RESET_ENABLE 1
`define WDCC_BIT_EVT_TIMEOUT 0
`define WDCC_BIT_EVT_RESET 1
`define WDCC_IRQ_W 2
`define WDCC_RST_CONTROL 2'h0
`define WDCC_RST_IRQ_MASK 2'h0
`define WDCC_CLEAR_READ_VALUE 32'h00000000
`endif

// >>> design/wdcc_lock.v
// Write lockout for the control register.
// Assumes single-cycle write strobes on clk; released only by sys_rst.
`timescale 1ns/100ps
`include "wdcc_regs.vh"
module wdcc_lock (
	clk,
	sys_rst,
	ctrl_wr,
	ctrl_wdata,
	int_enable,
	reset_enable
);
	input wire clk;
	input wire sys_rst;
	input wire ctrl_wr;
	input wire [1:0] ctrl_wdata;
	output wire int_enable;
	output wire reset_enable;

	reg [1:0] ctrl_q;
	wire locked;

	// Enable bit is itself the lock: no software path clears it once set
	assign locked = ctrl_q[`WDCC_BIT_INT_ENABLE];
	assign int_enable = ctrl_q[`WDCC_BIT_INT_ENABLE];
	assign reset_enable = ctrl_q[`WDCC_BIT_RESET_ENABLE];

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= `WDCC_RST_CONTROL;
		end else if (ctrl_wr && !locked) begin
			ctrl_q <= ctrl_wdata;
		end
	end
endmodule // wdcc_lock

// >>> design/wdcc_sticky.v
// Sticky event bits: set by hardware, cleared by writing one.
// Assumes events and clears are synchronous to clk.
`timescale 1ns/100ps
`include "wdcc_regs.vh"
module wdcc_sticky #(
	parameter W = `WDCC_IRQ_W
) (
	clk,
	sys_rst,
	set_evt,
	clr_wr,
	clr_mask,
	status
);
	input wire clk;
	input wire sys_rst;
	input wire [W-1:0] set_evt;
	input wire clr_wr;
	input wire [W-1:0] clr_mask;
	output reg [W-1:0] status;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status <= {W{1'b0}};
		end else begin
			// A set in the clear cycle wins so no event is lost
			status <= (status & ~(clr_wr ? clr_mask : {W{1'b0}})) | set_evt;
		end
	end
endmodule // wdcc_sticky

// >>> design/wdcc_top.v
// Watchdog control, interrupt clear and raw status, with register port.
// Assumes the counter core on clk gives a one-cycle zero pulse and takes
// a one-cycle reload pulse; the register master never waits.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "wdcc_regs.vh"
module wdcc_top (
	clk,
	sys_rst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	counter_zero,
	counter_reload,
	counter_enable,
	timeout_interrupt,
	system_reset_req,
	irq
);
	input wire clk;
	input wire sys_rst;
	input wire [`WDCC_ADDR_W-1:0] reg_addr;
	input wire [31:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output reg [31:0] reg_rdata;
	input wire counter_zero;
	output reg counter_reload;
	output wire counter_enable;
	output wire timeout_interrupt;
	output reg system_reset_req;
	output wire irq;

	function hit;
		input [`WDCC_ADDR_W-1:0] a;
		input [`WDCC_ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	wire int_enable;
	wire reset_enable;
	wire wr_ctrl;
	wire wr_clear;
	wire wr_irq_status;
	wire wr_irq_mask;
	reg raw_q;
	reg int_enable_q;
	reg [`WDCC_IRQ_W-1:0] irq_mask_q;
	wire [`WDCC_IRQ_W-1:0] irq_status;
	wire [`WDCC_IRQ_W-1:0] irq_evt;
	wire masked;
	wire second_timeout;
	reg [31:0] rdata_d;

	assign wr_ctrl = reg_wr && hit(reg_addr, `WDCC_OFF_CONTROL);
	assign wr_clear = reg_wr && hit(reg_addr, `WDCC_OFF_INT_CLEAR);
	assign wr_irq_status = reg_wr && hit(reg_addr, `WDCC_OFF_IRQ_STATUS);
	assign wr_irq_mask = reg_wr && hit(reg_addr, `WDCC_OFF_IRQ_MASK);

	wdcc_lock u_lock (
		.clk(clk),
		.sys_rst(sys_rst),
		.ctrl_wr(wr_ctrl),
		.ctrl_wdata(reg_wdata[1:0]),
		.int_enable(int_enable),
		.reset_enable(reset_enable)
	);

	assign counter_enable = int_enable;
	// Second zero while the first is still pending and uncleared
	assign second_timeout = counter_zero && raw_q && !wr_clear;

	// Raw time-out latch; set wins over a same-cycle clear
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			raw_q <= 1'b0;
		end else if (counter_zero) begin
			raw_q <= 1'b1;
		end else if (wr_clear) begin
			raw_q <= 1'b0;
		end
	end

	assign masked = raw_q & int_enable;
	assign timeout_interrupt = masked;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			counter_reload <= 1'b0;
			system_reset_req <= 1'b0;
			int_enable_q <= 1'b0;
		end else begin
			int_enable_q <= int_enable;
			// Reload on clear, on each time-out, and when enabling so the
			// count starts fresh rather than from a stale value
			counter_reload <= wr_clear || counter_zero || (int_enable && !int_enable_q);
			// Held until hardware reset: the system reset takes this block down too
			if (second_timeout && reset_enable) begin
				system_reset_req <= 1'b1;
			end
		end
	end

	assign irq_evt = {second_timeout && reset_enable, counter_zero};

	wdcc_sticky #(
		.W(`WDCC_IRQ_W)
	) u_sticky (
		.clk(clk),
		.sys_rst(sys_rst),
		.set_evt(irq_evt),
		.clr_wr(wr_irq_status),
		.clr_mask(reg_wdata[`WDCC_IRQ_W-1:0]),
		.status(irq_status)
	);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_mask_q <= `WDCC_RST_IRQ_MASK;
		end else if (wr_irq_mask) begin
			irq_mask_q <= reg_wdata[`WDCC_IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status & irq_mask_q);

	always @* begin
		rdata_d = 32'h00000000;
		case (reg_addr)
			`WDCC_OFF_CONTROL: rdata_d = {30'h00000000, reset_enable, int_enable};
			`WDCC_OFF_INT_CLEAR: rdata_d = `WDCC_CLEAR_READ_VALUE;
			`WDCC_OFF_RAW_STATUS: rdata_d = {31'h00000000, raw_q};
			`WDCC_OFF_MASKED_STATUS: rdata_d = {31'h00000000, masked};
			`WDCC_OFF_IRQ_STATUS: rdata_d = {30'h00000000, irq_status};
			`WDCC_OFF_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
			default: rdata_d = 32'h00000000;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule // wdcc_top

// >>> testbench/wdcc_chk_asserts.sv
// Port-level checker for the watchdog control block.
// Assumes one clock, clk, and the asynchronous reset sys_rst.
`timescale 1ns/100ps
`include "wdcc_regs.vh"
module wdcc_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [`WDCC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic counter_zero,
	input wire logic counter_reload,
	input wire logic counter_enable,
	input wire logic timeout_interrupt,
	input wire logic system_reset_req,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_clr;
		reg_wr && reg_addr == 12'h00C;
	endsequence
	chk_zero_reload: assert property (counter_zero |=> counter_reload)
		else $error("no reload after zero");
	chk_tint_set: assert property (counter_zero && counter_enable |=> timeout_interrupt)
		else $error("no interrupt after zero");
	chk_tint_mask: assert property (timeout_interrupt |-> counter_enable)
		else $error("interrupt while disabled");
	chk_clr_drop: assert property (s_clr ##0 !counter_zero |=>
		!timeout_interrupt && counter_reload)
		else $error("clear write ignored");
	chk_lock_hold: assert property (counter_enable |=> counter_enable)
		else $error("lock lost");
	chk_rst_hold: assert property (system_reset_req |=> system_reset_req)
		else $error("reset request dropped");
	chk_rst_cause: assert property ($rose(system_reset_req) |-> $past(counter_zero))
		else $error("reset request without zero");
	chk_ctrl_read: assert property (reg_rd && reg_addr == 12'h008 |=>
		reg_rdata[31:2] == 30'h0 && reg_rdata[0] == counter_enable)
		else $error("control read wrong");
	chk_clr_read: assert property (reg_rd && reg_addr == 12'h00C |=> reg_rdata == 32'h0)
		else $error("clear read not zero");
endmodule // wdcc_chk
bind wdcc_top wdcc_chk u_chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .counter_zero, .counter_reload, .counter_enable, .timeout_interrupt,
	.system_reset_req, .irq);

// >>> testbench/tb_top.sv
// Self-checking bench for the watchdog control block.
// Drives the register port and the counter zero pulse directly.
`timescale 1ns/100ps
module tb_top;
	reg clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, counter_zero = 0;
	reg [11:0] reg_addr = 12'h000;
	reg [31:0] reg_wdata = 32'h0;
	wire [31:0] reg_rdata;
	wire counter_reload, counter_enable, timeout_interrupt, system_reset_req, irq;
	int fail_count = 0, num_checks = 0;
	wdcc_top uut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.counter_zero, .counter_reload, .counter_enable, .timeout_interrupt,
		.system_reset_req, .irq);
	initial begin
		forever #5 clk = ~clk;
	end
	task ck(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task rst;
		@(posedge clk);
		sys_rst <= 1;
		repeat (4) @(posedge clk);
		sys_rst <= 0;
	endtask
	task wr(logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
		#1;
	endtask
	task rd(logic [11:0] a, logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		#1 ck("rdata", e, reg_rdata);
	endtask
	// Zero pulse; returns settled in the cycle after it was taken
	task zp;
		@(posedge clk);
		counter_zero <= 1;
		@(posedge clk);
		counter_zero <= 0;
		#1;
	endtask
	task t_open;
		rd(12'h008, 32'h0);
		wr(12'h008, 32'hFFFFFFFE);
		rd(12'h008, 32'h2);
		@(posedge clk);
		#1 ck("rdata_idle", 32'h0, reg_rdata);
		ck("enable", 0, counter_enable);
		rd(12'h00C, 32'h0);
		rd(12'h100, 32'h0);
		zp;
		ck("tint", 0, timeout_interrupt);
		rd(12'h010, 32'h1);
		rd(12'h014, 32'h0);
		wr(12'h00C, 32'h0);
		zp;
		ck("sreq", 0, system_reset_req);
		zp;
		ck("sreq", 1, system_reset_req);
	endtask
	task t_lock;
		rst;
		ck("sreq", 0, system_reset_req);
		wr(12'h008, 32'h1);
		ck("enable", 1, counter_enable);
		// Enabling preloads the counter one cycle after the enable lands
		@(posedge clk);
		#1 ck("reload", 1, counter_reload);
		wr(12'h008, 32'h2);
		rd(12'h008, 32'h1);
		zp;
		ck("tint", 1, timeout_interrupt);
		ck("reload", 1, counter_reload);
		zp;
		ck("sreq", 0, system_reset_req);
		wr(12'h00C, 32'hA5A5A5A5);
		ck("tint", 0, timeout_interrupt);
		ck("reload", 1, counter_reload);
		rst;
		wr(12'h008, 32'h2);
		rd(12'h008, 32'h2);
	endtask
	// Status bit 0 is the time-out event, bit 1 the reset-request event
	task t_irq;
		wr(12'h024, 32'h1);
		zp;
		ck("irq", 1, irq);
		wr(12'h020, 32'h1);
		ck("irq", 0, irq);
		// Raw status was never cleared, so this zero is a second time-out
		zp;
		ck("sreq", 1, system_reset_req);
		wr(12'h024, 32'h0);
		ck("irq", 0, irq);
		rd(12'h020, 32'h3);
	endtask
	task results;
		if (fail_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		rst;
		t_open;
		t_lock;
		t_irq;
		results;
	end
endmodule // tb_top
